// [include/cspst_pkg.sv]
// Package for the port 0 statistics counter bank
package cspst_pkg;

  localparam int unsigned CNT_W  = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_CNT = 4;
  localparam int unsigned ADDR_W = 12;

  // Printed offsets are not all multiples of four: they are register indexes
  localparam logic [7:0] IDX_FRAME_HIGH     = 8'h90;
  localparam logic [7:0] IDX_FRAME_LOW      = 8'h91;
  localparam logic [7:0] IDX_BAD_FRAME_HIGH = 8'h92;
  localparam logic [7:0] IDX_BAD_FRAME_LOW  = 8'h93;
  localparam logic [7:0] IDX_LINE_HIGH      = 8'h94;
  localparam logic [7:0] IDX_LINE_LOW       = 8'h95;
  localparam logic [7:0] IDX_BAD_LINE_HIGH  = 8'h96;
  localparam logic [7:0] IDX_BAD_LINE_LOW   = 8'h97;

  // Counter selectors in index order
  localparam logic [1:0] SEL_FRAME     = 2'h0;
  localparam logic [1:0] SEL_BAD_FRAME = 2'h1;
  localparam logic [1:0] SEL_LINE      = 2'h2;
  localparam logic [1:0] SEL_BAD_LINE  = 2'h3;

  localparam logic [CNT_W-1:0]  CNT_RESET  = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events reported by the port 0 transmitter, one-cycle pulses
  typedef struct packed {
    logic frame_done;
    logic frame_err;
    logic line_done;
    logic line_err;
  } cspst_evt_s;

  // Read-side decode handed to the counter cells
  typedef struct packed {
    logic       hit;
    logic       high;
    logic [1:0] sel;
  } cspst_dec_s;

endpackage

// [rtl/cspst_tally.sv]
// One 16-bit event counter with read-to-clear high byte and low-byte snapshot
`timescale 1ns/1ns
module cspst_tally
  import cspst_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              incr,
  input  wire logic              take,
  output logic [BYTE_W-1:0]      high_byte,
  output logic [BYTE_W-1:0]      low_snap
);

  logic [CNT_W-1:0] tally;
  logic [CNT_W-1:0] next_tally;
  logic [CNT_W-1:0] bumped;

  // Saturate so a slow reader sees a full count, not a wrapped one
  assign bumped     = (&tally) ? tally : tally + 16'h0001;
  // A read clears the counter; an event in the same cycle is kept as one count
  assign next_tally = take ? (incr ? 16'h0001 : CNT_RESET)
                           : (incr ? bumped : tally);
  assign high_byte  = tally[CNT_W-1:BYTE_W];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tally    <= CNT_RESET;
      low_snap <= BYTE_RESET;
    end else begin
      tally <= next_tally;
      if (take) begin
        low_snap <= tally[BYTE_W-1:0];
      end
    end
  end

  cnt_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && !incr |=> tally == CNT_RESET)
    else $error("Counter not cleared by high-byte read");
  snap_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take |=> low_snap == $past(tally[BYTE_W-1:0]))
    else $error("Low byte not captured on high-byte read");
  snap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !take |=> $stable(low_snap))
    else $error("Low byte changed without high-byte read");

endmodule // cspst_tally

// [rtl/cspst_axil.sv]
// AXI4-Lite slave front end: one read and one write at a time
`timescale 1ns/1ns
module cspst_axil
  import cspst_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic                   rd_take,
  input  wire logic [1:0]        rd_resp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  logic aw_got;
  logic w_got;
  logic next_aw_got;
  logic next_w_got;
  logic both_in;
  logic next_aw_hold;
  logic next_w_hold;
  logic next_bvalid;
  logic next_rvalid;

  // Write side: all registers are read-only, so every write gets SLVERR
  assign next_aw_got  = aw_got || (s_axi_awvalid && s_axi_awready);
  assign next_w_got   = w_got || (s_axi_wvalid && s_axi_wready);
  assign both_in      = next_aw_got && next_w_got && !s_axi_bvalid;
  assign next_aw_hold = both_in ? 1'b0 : next_aw_got;
  assign next_w_hold  = both_in ? 1'b0 : next_w_got;
  assign next_bvalid  = s_axi_bvalid ? !s_axi_bready : both_in;
  // Read side: address accepted only when no answer is pending
  assign rd_take      = s_axi_arvalid && s_axi_arready;
  assign next_rvalid  = rd_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      aw_got        <= next_aw_hold;
      w_got         <= next_w_hold;
      s_axi_bvalid  <= next_bvalid;
      s_axi_rvalid  <= next_rvalid;
      // Readies are flops fed from next state, so the pins never glitch
      s_axi_awready <= !next_aw_hold && !next_bvalid;
      s_axi_wready  <= !next_w_hold && !next_bvalid;
      s_axi_arready <= !next_rvalid;
      if (both_in) begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end
  end

  rd_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_take |=> s_axi_rvalid)
    else $error("Read answer not given one cycle after address");
  wr_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken");

endmodule // cspst_axil

// [rtl/cspst_bank.sv]
// Port 0 statistics counter bank behind an AXI4-Lite slave
//
// Functional notes
// - Frame high-byte read returns bits 15:8, snapshots low byte, clears counter.
// - Frame low-byte register returns the snapshot taken at the last high-byte read.
// - Bad-frame high-byte read returns bits 15:8, snapshots low byte, clears counter.
// - Bad-frame low-byte register returns the snapshot from its last high-byte read.
// - Line high-byte read returns bits 15:8, snapshots low byte, clears counter.
// - Line low-byte register returns the snapshot from its last high-byte read.
// - Bad-line high-byte read returns bits 15:8, snapshots low byte, clears counter.
`timescale 1ns/1ns
module cspst_bank
  import cspst_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire cspst_evt_s        port0_evt,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  logic       rd_take;
  cspst_dec_s rd_dec;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic       rd_ok;

  cspst_axil u_axil (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .rd_take       (rd_take),
    .rd_resp       (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );

  // Byte address is four times the index; the low two bits are ignored
  assign rd_idx      = s_axi_araddr[9:2];
  assign rd_ok       = (s_axi_araddr[ADDR_W-1:10] == 2'h0)
                    && (rd_idx >= IDX_FRAME_HIGH) && (rd_idx <= IDX_BAD_LINE_LOW);
  assign rd_dec.hit  = rd_ok;
  assign rd_dec.high = !rd_idx[0];
  assign rd_dec.sel  = rd_idx[2:1];

  ////////////////////////////////////////////////////////////////////////////
  // Counter cells

  logic [NUM_CNT-1:0]        incr;
  logic [NUM_CNT-1:0]        take;
  logic [BYTE_W-1:0]         high_byte [NUM_CNT];
  logic [BYTE_W-1:0]         low_snap  [NUM_CNT];

  // Errored counts only move when the finished frame or line was bad
  assign incr[SEL_FRAME]     = port0_evt.frame_done;
  assign incr[SEL_BAD_FRAME] = port0_evt.frame_done && port0_evt.frame_err;
  assign incr[SEL_LINE]      = port0_evt.line_done;
  assign incr[SEL_BAD_LINE]  = port0_evt.line_done && port0_evt.line_err;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      // Only a high-byte read snapshots and clears, so order matters to software
      assign take[gi] = rd_take && rd_dec.hit && rd_dec.high
                     && (rd_dec.sel == 2'(gi));
      cspst_tally u_tally (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .incr      (incr[gi]),
        .take      (take[gi]),
        .high_byte (high_byte[gi]),
        .low_snap  (low_snap[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data path

  // High reads return live bits 15:8, low reads the snapshot
  assign rd_byte = rd_dec.high ? high_byte[rd_dec.sel]
                               : low_snap[rd_dec.sel];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rdata <= rd_dec.hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      s_axi_rresp <= rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence high_read_s(int s);
    rd_take && rd_dec.hit && rd_dec.high && rd_dec.sel == 2'(s);
  endsequence

  sequence low_read_s(int s);
    rd_take && rd_dec.hit && !rd_dec.high && rd_dec.sel == 2'(s);
  endsequence

  frame_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(0) |=> s_axi_rdata[7:0] == $past(high_byte[0]))
    else $error("Frame high byte read wrong");
  frame_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(0) ##2 low_read_s(0) |=> s_axi_rdata[7:0] == low_snap[0])
    else $error("Frame low byte not the snapshot");
  bad_frame_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(1) ##0 !incr[1] |=> high_byte[1] == 8'h00)
    else $error("Bad-frame counter not cleared");
  bad_frame_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_take && rd_dec.hit && !rd_dec.high && rd_dec.sel == 2'h1
      |=> s_axi_rdata[7:0] == $past(low_snap[1]))
    else $error("Bad-frame low byte not the snapshot");
  line_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(2) ##0 !incr[2] |=> high_byte[2] == 8'h00)
    else $error("Line counter not cleared");
  line_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_take && rd_dec.hit && !rd_dec.high && rd_dec.sel == 2'h2
      |=> s_axi_rdata[7:0] == $past(low_snap[2]))
    else $error("Line low byte not the snapshot");
  bad_line_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(3) |=> s_axi_rdata[7:0] == $past(high_byte[3]) && s_axi_rdata[31:8] == 0)
    else $error("Bad-line high byte read wrong");
  bad_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !port0_evt.frame_done |-> !incr[SEL_BAD_FRAME])
    else $error("Bad-frame count moved without a frame");
  unmapped_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_take && !rd_dec.hit |=> s_axi_rresp == RESP_SLVERR ##0 s_axi_rvalid)
    else $error("Unmapped read not answered with SLVERR");
  frame_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(0) ##0 !incr[0] |=> high_byte[0] == 8'h00)
    else $error("Frame counter not cleared");
  low_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_read_s(0) ##0 !incr[0] |=> high_byte[0] == $past(high_byte[0]))
    else $error("Frame low-byte read disturbed the counter");
  bad_frame_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(1) |=> s_axi_rdata[7:0] == $past(high_byte[1]))
    else $error("Bad-frame high byte read wrong");
  line_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(2) |=> s_axi_rdata[7:0] == $past(high_byte[2]))
    else $error("Line high byte read wrong");
  bad_line_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    high_read_s(3) ##0 !incr[3] |=> high_byte[3] == 8'h00)
    else $error("Bad-line counter not cleared");
  bad_line_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    low_read_s(3) |=> s_axi_rdata[7:0] == $past(low_snap[3]))
    else $error("Bad-line low byte not the snapshot");
  hit_okay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_take && rd_dec.hit |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("Mapped read not answered OKAY with zero upper bits");
  read_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted while an answer is pending");
  write_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_bvalid |-> s_axi_bresp == RESP_SLVERR)
    else $error("Write to read-only bank not refused");

endmodule // cspst_bank

// [test/cspst_bank_tb_top.sv]
// Self-checking testbench for the port 0 statistics counter bank
`timescale 1ns/1ns
module cspst_bank_tb_top
  import cspst_pkg::*;
;
  logic              sys_clk;
  logic              rst_n;
  cspst_evt_s        port0_evt;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]       wdata, rdata;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [15:0]       m [4];
  logic [7:0]        s [4];
  int                error_cnt, checks;

  cspst_bank u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .port0_evt(port0_evt),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Master holds arvalid until arready; rready stays high once raised
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr  <= ADDR_W'({idx, 2'b00});
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  // Address and data offered together, each released on its own handshake
  task automatic wr(input logic [7:0] idx);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    awaddr  <= ADDR_W'({idx, 2'b00});
    wdata   <= $urandom;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) a = 1'b1;
      if (wready === 1'b1) w = 1'b1;
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(a && w));
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    // Late bready: the response must stand until it is taken
    bready <= 1'b1;
    @(posedge sys_clk);
    chk({31'h0, bvalid}, 32'h0000_0001);
    chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
    bready <= 1'b0;
  endtask

  // Saturating step of one counter model
  function automatic logic [15:0] bump(input logic [15:0] v, input logic ev);
    return (ev && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  // Random event pulses; errors without a done pulse must not count
  task automatic evts(input int n);
    cspst_evt_s e;
    for (int i = 0; i < n; i++) begin
      e = cspst_evt_s'(4'($urandom));
      port0_evt <= e;
      @(posedge sys_clk);
      m[0] = bump(m[0], e.frame_done);
      m[1] = bump(m[1], e.frame_done && e.frame_err);
      m[2] = bump(m[2], e.line_done);
      m[3] = bump(m[3], e.line_done && e.line_err);
    end
    port0_evt <= '0;
    @(posedge sys_clk);
  endtask

  // Reads all eight registers, expects the model values
  task automatic rd_pairs();
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    k = $urandom % 4;
    for (int j = 0; j < 4; j++) begin
      int c = (j + k) % 4;
      rd(IDX_FRAME_HIGH + 8'(2 * c), d, r);
      chk(d, {24'h0000_00, m[c][15:8]});
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      s[c] = m[c][7:0];
      m[c] = 16'h0000;
    end
    // Counting resumes, yet the snapshot must not follow the live count
    evts(40);
    for (int c = 0; c < 4; c++) begin
      rd(IDX_FRAME_LOW + 8'(2 * c), d, r);
      chk(d, {24'h0000_00, s[c]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    rst_n = 1'b0;
    port0_evt = '0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(24));
    for (int pass = 0; pass < 2; pass++) begin
      rst_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 4; c++) begin
        m[c] = 16'h0000;
        s[c] = 8'h00;
      end
      // Reset values, low byte read alone keeps its old snapshot
      for (int i = 0; i < 8; i++) begin
        rd(IDX_FRAME_HIGH + 8'(i), d, r);
        chk(d, 32'h0000_0000);
      end
      evts(700);
      wr(IDX_FRAME_HIGH);
      rd(IDX_LINE_LOW, d, r);
      chk(d, 32'h0000_0000);
      rd_pairs();
      evts(300);
      rd_pairs();
      // Unmapped neighbours answer an error with no side effect
      rd(8'h98, d, r);
      chk(d, 32'h0000_0000);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h8f, d, r);
      chk(d, 32'h0000_0000);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd_pairs();
      evts(20);
    end
    wrap_up();
  end

  // Whole run is far below this span; reaching it means a hung handshake
  initial begin
    #(20 * 20000);
    error_cnt++;
    wrap_up();
  end
endmodule // cspst_bank_tb_top
